//--- hw/rdce_regs.svh
// Register offsets, command codes, field positions and reset values of the direct command engine.
`ifndef RDCE_REGS_SVH
`define RDCE_REGS_SVH
`define RDCE_MODE_WRITE 2'h0
`define RDCE_MODE_CMD 2'h2
`define RDCE_ADDR_TX_SETTINGS 6'h3C
`define RDCE_ADDR_TX_LEN_HI 6'h3D
`define RDCE_ADDR_TX_LEN_LO 6'h3E
`define RDCE_ADDR_FIFO 6'h3F
`define RDCE_RST_TX_SETTINGS 8'h00
`define RDCE_RST_TX_LEN 8'h00
`define RDCE_SESS_MSB 1
`define RDCE_SESS_LSB 0
`define RDCE_RN_BYTES 2'h2
`define RDCE_CMD_IDLE 8'h80
`define RDCE_CMD_DIRECT 8'h81
`define RDCE_CMD_SOFT_INIT 8'h83
`define RDCE_CMD_HOP_MAIN 8'h84
`define RDCE_CMD_HOP_AUX 8'h85
`define RDCE_CMD_ADC 8'h87
`define RDCE_CMD_CAL 8'h88
`define RDCE_CMD_CAL_DOWN 8'h89
`define RDCE_CMD_CAL_UP 8'h8A
`define RDCE_CMD_TX_CRC 8'h90
`define RDCE_CMD_TX_HDR 8'h91
`define RDCE_CMD_TX_RAW 8'h92
`define RDCE_CMD_BLOCK_RX 8'h96
`define RDCE_CMD_ENABLE_RX 8'h97
`define RDCE_CMD_QUERY 8'h98
`define RDCE_CMD_QREP 8'h99
`define RDCE_CMD_QADJ_UP 8'h9A
`define RDCE_CMD_QADJ_NIC 8'h9B
`define RDCE_CMD_QADJ_DOWN 8'h9C
`define RDCE_CMD_ACK 8'h9D
`define RDCE_CMD_NAK 8'h9E
`define RDCE_CMD_REQRN 8'h9F
`define RDCE_CMD_REG_AUTO 8'hA2
`define RDCE_CMD_REG_MAN 8'hA3
`define RDCE_CMD_VCO_AUTO 8'hA4
`define RDCE_CMD_VCO_MAN 8'hA5
`define RDCE_CMD_GAIN_ON 8'hA6
`define RDCE_CMD_GAIN_OFF 8'hA7
`define RDCE_CMD_RSSI_STORE 8'hA8
`define RDCE_CMD_RSSI_CLEAR 8'hA9
`define RDCE_CMD_ACOL_ON 8'hAA
`define RDCE_CMD_ACOL_OFF 8'hAB
`endif

//--- hw/rdce_pkg.sv
// Types shared by the direct command engine.
`default_nettype none
package rdce_pkg;
   typedef enum logic [2:0] {FRM_RAW, FRM_QUERY, FRM_QREP, FRM_QADJ, FRM_ACK, FRM_NAK, FRM_REQRN} rdce_frame_t;
   typedef enum logic [1:0] {ADJ_UP, ADJ_NIC, ADJ_DOWN} rdce_adj_t;
   typedef enum logic [1:0] {PH_MODE, PH_WDATA, PH_SKIP} rdce_phase_t;
   typedef struct packed {
      logic go;
      rdce_frame_t frame;
      logic crc16;
      logic header;
      rdce_adj_t adj;
      logic [1:0] sess;
      logic [14:0] param;
      logic [15:0] rn;
   } rdce_tx_req_t;
   typedef struct packed {
      logic direct_mode;
      logic aux_freq;
      logic rx_blocked;
      logic reg_auto;
      logic vco_auto;
      logic gain_loop_control;
      logic anticoll;
      logic busy;
   } rdce_status_t;
   typedef struct packed {
      logic soft_init;
      logic adc_start;
      logic cal_start;
      logic cal_down;
      logic cal_up;
      logic rx_enable;
      logic rssi_store;
      logic rssi_clear;
      logic reg_auto_start;
      logic vco_auto_start;
      logic cmd_done;
   } rdce_pulse_t;
   typedef struct packed {
      logic push;
      logic [7:0] data;
   } rdce_fifo_t;
   typedef struct packed {
      logic [7:0] data;
      logic first;
      logic tog;
   } rdce_link_t;
   typedef struct packed {
      rdce_phase_t phase;
      logic [5:0] addr;
      logic tog_prev;
      logic [7:0] settings;
      logic [7:0] len_hi;
      logic [7:0] len_lo;
      logic tx_armed;
      logic arm_crc;
      logic arm_hdr;
      logic query_wait;
      logic query_have;
      logic [7:0] query_b0;
      logic expect_rn;
      logic [1:0] rn_push;
      logic [15:0] handle;
      rdce_status_t status;
      rdce_pulse_t pulse;
      rdce_tx_req_t tx;
      rdce_fifo_t fifo;
   } rdce_state_t;
endpackage : rdce_pkg
`default_nettype wire

//--- hw/rdce_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain.
`default_nettype none
module rdce_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock.
   input wire logic clk_i,
   // Level from the other domain and its synchronised copy.
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [1:0][WIDTH-1:0] stage_reg;

   // The first stage is read only by the second one.
   always_ff @(posedge clk_i) begin
      stage_reg <= {stage_reg[0], d_i};
   end

   assign q_o = stage_reg[1];
endmodule // rdce_sync
`default_nettype wire

//--- hw/rdce_top.sv
// Direct command engine: byte capture on the link clock and command execution on the system clock.
`include "rdce_regs.svh"
`default_nettype none
module rdce_top
   import rdce_pkg::*;
(
   // System clock and reset.
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   // Byte strobe from the serial framer on the link clock.
   input wire logic LINK_CLK_I,
   input wire logic LINK_BYTE_STB_I,
   input wire logic LINK_BYTE_FIRST_I,
   input wire logic [7:0] LINK_BYTE_I,
   // Events from analog units, receive timer and decoder.
   input wire logic OP_DONE_I,
   input wire logic RX_WAIT_DONE_I,
   input wire logic RN_VALID_I,
   input wire logic [15:0] RN_I,
   // Control towards transmitter, FIFO and analog units.
   output rdce_status_t STATUS_O,
   output rdce_pulse_t PULSE_O,
   output rdce_tx_req_t TX_REQ_O,
   output rdce_fifo_t FIFO_O,
   output logic [15:0] TX_LEN_O,
   output logic [7:0] TX_SETTINGS_O,
   output logic [15:0] HANDLE_O
);
   rdce_link_t l, l_next;
   rdce_state_t s, s_next;
   logic link_rst_b;
   logic tog_sys;
   logic byte_ev;
   logic cmd_ev;
   logic host_wr;
   logic q_issue;
   logic known;
   logic long_op;

   // Reset reaches the link domain through a synchroniser.
   rdce_sync #(.WIDTH(1)) u_rst_sync (
      .clk_i(LINK_CLK_I),
      .d_i(RST_B_I),
      .q_o(link_rst_b)
   );

   // Each received byte flips the toggle; the data word is held until the next byte.
   always_comb begin
      l_next = l;
      if (LINK_BYTE_STB_I) begin
         l_next.data = LINK_BYTE_I;
         l_next.first = LINK_BYTE_FIRST_I;
         l_next.tog = ~l.tog;
      end
   end

   // Link domain state.
   always_ff @(posedge LINK_CLK_I) begin
      if (!link_rst_b) begin
         l <= '0;
      end else begin
         l <= l_next;
      end
   end

   // The toggle crosses into the system domain.
   rdce_sync #(.WIDTH(1)) u_tog_sync (
      .clk_i(CLOCK_I),
      .d_i(l.tog),
      .q_o(tog_sys)
   );

   // Builds one transmit request for the transmitter.
   function automatic rdce_tx_req_t mk_tx(input rdce_frame_t f, input logic crc, input logic hdr,
                                          input rdce_adj_t adj, input logic [1:0] sess,
                                          input logic [14:0] prm, input logic [15:0] rn);
      rdce_tx_req_t r;
      r.go = 1'b1;
      r.frame = f;
      r.crc16 = crc;
      r.header = hdr;
      r.adj = adj;
      r.sess = sess;
      r.param = prm;
      r.rn = rn;
      return r;
   endfunction

   // Byte decoding, register writes and command execution.
   always_comb begin
      s_next = s;
      s_next.pulse = '0;
      s_next.fifo.push = 1'b0;
      s_next.tx.go = 1'b0;
      s_next.tog_prev = tog_sys;
      byte_ev = tog_sys != s.tog_prev;
      cmd_ev = byte_ev && (l.first || s.phase == PH_MODE) && l.data[7:6] == `RDCE_MODE_CMD;
      host_wr = byte_ev && !l.first && s.phase == PH_WDATA && s.addr == `RDCE_ADDR_FIFO && !s.query_wait;
      q_issue = byte_ev && !l.first && s.phase == PH_WDATA && s.addr == `RDCE_ADDR_FIFO && s.query_wait
                && s.query_have;
      known = 1'b0;
      long_op = 1'b0;
      // A lasting operation reports its end as command done.
      if (OP_DONE_I && s.status.busy) begin
         s_next.status.busy = 1'b0;
         s_next.pulse.cmd_done = 1'b1;
      end
      // Receiver comes back after the wait time that follows a transmission.
      if (RX_WAIT_DONE_I) begin
         s_next.status.rx_blocked = 1'b0;
      end
      // A tag reply is kept as the handle and queued for the FIFO.
      if (RN_VALID_I && s.expect_rn) begin
         s_next.handle = RN_I;
         s_next.expect_rn = 1'b0;
         s_next.rn_push = `RDCE_RN_BYTES;
      end
      if (byte_ev) begin
         if (l.first || s.phase == PH_MODE) begin
            s_next.addr = l.data[5:0];
            unique case (l.data[7:6])
               `RDCE_MODE_WRITE: s_next.phase = PH_WDATA;
               `RDCE_MODE_CMD: s_next.phase = PH_MODE;
               default: s_next.phase = PH_SKIP;
            endcase
         end else if (s.phase == PH_WDATA) begin
            // The FIFO port keeps its address so that payload bytes stream into it.
            if (s.addr != `RDCE_ADDR_FIFO) begin
               s_next.addr = s.addr + 6'h01;
            end
            unique case (s.addr)
               `RDCE_ADDR_TX_SETTINGS: s_next.settings = l.data;
               `RDCE_ADDR_TX_LEN_HI: s_next.len_hi = l.data;
               `RDCE_ADDR_TX_LEN_LO: s_next.len_lo = l.data;
               `RDCE_ADDR_FIFO: begin
                  if (s.query_wait && !s.query_have) begin
                     s_next.query_b0 = l.data;
                     s_next.query_have = 1'b1;
                  end else if (q_issue) begin
                     // Only the upper 15 of the 16 parameter bits are sent.
                     s_next.tx = mk_tx(FRM_QUERY, 1'b0, 1'b0, ADJ_NIC, s.settings[`RDCE_SESS_MSB:`RDCE_SESS_LSB],
                                       {s.query_b0, l.data[7:1]}, s.handle);
                     s_next.query_wait = 1'b0;
                     s_next.query_have = 1'b0;
                     s_next.expect_rn = 1'b1;
                  end else begin
                     s_next.fifo.push = 1'b1;
                     s_next.fifo.data = l.data;
                     // An armed transmit starts with its first payload byte.
                     if (s.tx_armed) begin
                        s_next.tx = mk_tx(FRM_RAW, s.arm_crc, s.arm_hdr, ADJ_NIC,
                                          s.settings[`RDCE_SESS_MSB:`RDCE_SESS_LSB], 15'h0000, s.handle);
                        s_next.tx_armed = 1'b0;
                     end
                  end
               end
               default: s_next.addr = s_next.addr;
            endcase
         end
      end
      // Direct commands.
      if (cmd_ev) begin
         known = 1'b1;
         unique case (l.data)
            `RDCE_CMD_IDLE: known = 1'b1;
            `RDCE_CMD_DIRECT: s_next.status.direct_mode = 1'b1;
            `RDCE_CMD_SOFT_INIT: begin
               s_next.settings = `RDCE_RST_TX_SETTINGS;
               s_next.len_hi = `RDCE_RST_TX_LEN;
               s_next.len_lo = `RDCE_RST_TX_LEN;
               s_next.tx_armed = 1'b0;
               s_next.query_wait = 1'b0;
               s_next.query_have = 1'b0;
               s_next.expect_rn = 1'b0;
               s_next.rn_push = 2'h0;
               s_next.status = '0;
               s_next.status.direct_mode = s.status.direct_mode;
               s_next.pulse.cmd_done = 1'b0;
               s_next.pulse.soft_init = 1'b1;
            end
            `RDCE_CMD_HOP_MAIN: s_next.status.aux_freq = 1'b0;
            `RDCE_CMD_HOP_AUX: s_next.status.aux_freq = 1'b1;
            `RDCE_CMD_ADC: begin
               s_next.pulse.adc_start = 1'b1;
               long_op = 1'b1;
            end
            `RDCE_CMD_CAL: begin
               s_next.pulse.cal_start = 1'b1;
               long_op = 1'b1;
            end
            `RDCE_CMD_CAL_DOWN: s_next.pulse.cal_down = 1'b1;
            `RDCE_CMD_CAL_UP: s_next.pulse.cal_up = 1'b1;
            `RDCE_CMD_TX_CRC, `RDCE_CMD_TX_HDR, `RDCE_CMD_TX_RAW: begin
               s_next.tx_armed = 1'b1;
               s_next.arm_crc = l.data != `RDCE_CMD_TX_RAW;
               s_next.arm_hdr = l.data == `RDCE_CMD_TX_HDR;
            end
            `RDCE_CMD_BLOCK_RX: s_next.status.rx_blocked = 1'b1;
            `RDCE_CMD_ENABLE_RX: begin
               s_next.status.rx_blocked = 1'b0;
               s_next.pulse.rx_enable = 1'b1;
            end
            `RDCE_CMD_QUERY: begin
               s_next.query_wait = 1'b1;
               s_next.query_have = 1'b0;
            end
            `RDCE_CMD_QREP: begin
               s_next.tx = mk_tx(FRM_QREP, 1'b0, 1'b0, ADJ_NIC, s.settings[`RDCE_SESS_MSB:`RDCE_SESS_LSB],
                                 15'h0000, s.handle);
               s_next.expect_rn = 1'b1;
            end
            `RDCE_CMD_QADJ_UP, `RDCE_CMD_QADJ_NIC, `RDCE_CMD_QADJ_DOWN: begin
               s_next.tx = mk_tx(FRM_QADJ, 1'b0, 1'b0,
                                 l.data == `RDCE_CMD_QADJ_UP ? ADJ_UP :
                                 l.data == `RDCE_CMD_QADJ_DOWN ? ADJ_DOWN : ADJ_NIC,
                                 s.settings[`RDCE_SESS_MSB:`RDCE_SESS_LSB], 15'h0000, s.handle);
               s_next.expect_rn = 1'b1;
            end
            `RDCE_CMD_ACK: s_next.tx = mk_tx(FRM_ACK, 1'b0, 1'b0, ADJ_NIC, 2'h0, 15'h0000, s.handle);
            `RDCE_CMD_NAK: s_next.tx = mk_tx(FRM_NAK, 1'b0, 1'b0, ADJ_NIC, 2'h0, 15'h0000, s.handle);
            `RDCE_CMD_REQRN: begin
               s_next.tx = mk_tx(FRM_REQRN, 1'b0, 1'b0, ADJ_NIC, 2'h0, 15'h0000, s.handle);
               s_next.expect_rn = 1'b1;
            end
            `RDCE_CMD_REG_AUTO: begin
               s_next.status.reg_auto = 1'b1;
               s_next.pulse.reg_auto_start = 1'b1;
               long_op = 1'b1;
            end
            `RDCE_CMD_REG_MAN: s_next.status.reg_auto = 1'b0;
            `RDCE_CMD_VCO_AUTO: begin
               s_next.status.vco_auto = 1'b1;
               s_next.pulse.vco_auto_start = 1'b1;
               long_op = 1'b1;
            end
            `RDCE_CMD_VCO_MAN: s_next.status.vco_auto = 1'b0;
            `RDCE_CMD_GAIN_ON: s_next.status.gain_loop_control = 1'b1;
            `RDCE_CMD_GAIN_OFF: s_next.status.gain_loop_control = 1'b0;
            `RDCE_CMD_RSSI_STORE: s_next.pulse.rssi_store = 1'b1;
            `RDCE_CMD_RSSI_CLEAR: s_next.pulse.rssi_clear = 1'b1;
            `RDCE_CMD_ACOL_ON: s_next.status.anticoll = 1'b1;
            `RDCE_CMD_ACOL_OFF: s_next.status.anticoll = 1'b0;
            default: known = 1'b0;
         endcase
         // Immediate commands finish at once, lasting ones when their unit reports.
         if (known && !long_op) begin
            s_next.pulse.cmd_done = 1'b1;
         end
         if (long_op) begin
            s_next.status.busy = 1'b1;
         end
      end
      // Handle bytes go to the FIFO, high byte first, whenever the host is not writing it.
      if (s.rn_push != 2'h0 && !s_next.fifo.push && s_next.rn_push != 2'h0) begin
         s_next.fifo.push = 1'b1;
         s_next.fifo.data = s.rn_push == `RDCE_RN_BYTES ? s.handle[15:8] : s.handle[7:0];
         s_next.rn_push = s.rn_push - 2'h1;
      end
   end

   // System domain state.
   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         s <= '0;
         s.settings <= `RDCE_RST_TX_SETTINGS;
         s.len_hi <= `RDCE_RST_TX_LEN;
         s.len_lo <= `RDCE_RST_TX_LEN;
      end else begin
         s <= s_next;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign STATUS_O = s.status;
   assign PULSE_O = s.pulse;
   assign TX_REQ_O = s.tx;
   assign FIFO_O = s.fifo;
   assign TX_LEN_O = {s.len_hi, s.len_lo};
   assign TX_SETTINGS_O = s.settings;
   assign HANDLE_O = s.handle;

   // Checks on the system clock.
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);

   AST_DIRECT_MODE: assert property (cmd_ev && l.data == `RDCE_CMD_DIRECT |=> STATUS_O.direct_mode)
      else $error("Direct mode not entered.");
   AST_SOFT_INIT: assert property (cmd_ev && l.data == `RDCE_CMD_SOFT_INIT
      |=> PULSE_O.soft_init && !STATUS_O.busy && TX_LEN_O == {`RDCE_RST_TX_LEN, `RDCE_RST_TX_LEN})
      else $error("Soft init did not restore defaults.");
   AST_HOP: assert property (cmd_ev && (l.data == `RDCE_CMD_HOP_MAIN || l.data == `RDCE_CMD_HOP_AUX)
      |=> STATUS_O.aux_freq == $past(l.data[0]))
      else $error("Frequency set selection wrong.");
   AST_ADC_LONG: assert property (cmd_ev && l.data == `RDCE_CMD_ADC && !OP_DONE_I
      |=> PULSE_O.adc_start && STATUS_O.busy && !PULSE_O.cmd_done)
      else $error("Conversion start not handled as lasting operation.");
   AST_TX_FIRST_BYTE: assert property (host_wr && s.tx_armed
      |=> TX_REQ_O.go && TX_REQ_O.frame == FRM_RAW && FIFO_O.push && TX_REQ_O.crc16 == $past(s.arm_crc))
      else $error("Transmit did not start on first payload byte.");
   AST_BLOCK_RX: assert property (cmd_ev && l.data == `RDCE_CMD_BLOCK_RX |=> STATUS_O.rx_blocked)
      else $error("Receiver not blocked.");
   AST_ENABLE_RX: assert property (cmd_ev && l.data == `RDCE_CMD_ENABLE_RX
      |=> !STATUS_O.rx_blocked && PULSE_O.rx_enable)
      else $error("Receiver not re-enabled.");
   AST_QUERY_PARAM: assert property (q_issue
      |=> TX_REQ_O.go && TX_REQ_O.frame == FRM_QUERY && TX_REQ_O.param == {$past(s.query_b0), $past(l.data[7:1])})
      else $error("Query parameters wrong.");
   AST_RN_SAVE: assert property (RN_VALID_I && s.expect_rn && !cmd_ev
      |=> HANDLE_O == $past(RN_I) ##1 (FIFO_O.push || s.rn_push == `RDCE_RN_BYTES))
      else $error("Reply not saved as handle.");
   AST_ACK_HANDLE: assert property (cmd_ev && l.data == `RDCE_CMD_ACK
      |=> TX_REQ_O.go && TX_REQ_O.frame == FRM_ACK && TX_REQ_O.rn == $past(s.handle))
      else $error("ACK does not carry the handle.");
   AST_DONE_GAIN: assert property (cmd_ev && l.data == `RDCE_CMD_GAIN_ON
      |=> PULSE_O.cmd_done && STATUS_O.gain_loop_control)
      else $error("Command done missing.");
   AST_UNKNOWN: assert property (cmd_ev && !known && !OP_DONE_I && !RX_WAIT_DONE_I
      |=> !PULSE_O.cmd_done && STATUS_O == $past(STATUS_O))
      else $error("Unknown command changed state.");
   AST_TX_ARM: assert property (cmd_ev && l.data == `RDCE_CMD_TX_HDR
      |=> s.tx_armed && s.arm_crc && s.arm_hdr)
      else $error("Header-bit transmit not armed.");
   AST_RX_UNBLOCK: assert property (RX_WAIT_DONE_I && !cmd_ev
      |=> !STATUS_O.rx_blocked)
      else $error("Receiver still blocked after wait time.");
   AST_QREP_SESS: assert property (cmd_ev && l.data == `RDCE_CMD_QREP
      |=> TX_REQ_O.go && TX_REQ_O.frame == FRM_QREP
          && TX_REQ_O.sess == $past(s.settings[`RDCE_SESS_MSB:`RDCE_SESS_LSB]))
      else $error("QueryRep session bits wrong.");
   AST_REQRN_HANDLE: assert property (cmd_ev && l.data == `RDCE_CMD_REQRN
      |=> TX_REQ_O.go && TX_REQ_O.frame == FRM_REQRN && TX_REQ_O.rn == $past(s.handle))
      else $error("Request for a new number lacks the handle.");
   AST_LONG_DONE: assert property (OP_DONE_I && s.status.busy && !cmd_ev
      |=> PULSE_O.cmd_done && !STATUS_O.busy)
      else $error("Lasting operation end not reported.");

   COV_QUERY: cover property (q_issue ##[1:200] RN_VALID_I);
   COV_TX_RAW: cover property (TX_REQ_O.go && TX_REQ_O.frame == FRM_RAW);
   COV_SOFT_INIT: cover property (PULSE_O.soft_init);
   COV_LONG_DONE: cover property (STATUS_O.busy ##1 PULSE_O.cmd_done);
   COV_RX_UNBLOCK: cover property (STATUS_O.rx_blocked ##1 !STATUS_O.rx_blocked);
endmodule // rdce_top
`default_nettype wire

//--- bench/rdce_host_model.sv
// Host side model: hands framed bytes to the engine on the link clock.
`default_nettype none
module rdce_host_model (
   // Link clock from the bench.
   input wire logic link_clk_i,
   // Byte strobe, first flag and byte towards the engine.
   output logic stb_o,
   output logic first_o,
   output logic [7:0] byte_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle lines at time zero.
   initial begin
      stb_o = 1'b0;
      first_o = 1'b0;
      byte_o = 8'h00;
   end
   // Sends one frame; the gap keeps bytes well over six system cycles apart.
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(negedge link_clk_i);
         stb_o = 1'b1;
         first_o = (i == 0);
         byte_o = b[i];
         @(negedge link_clk_i);
         stb_o = 1'b0;
         first_o = 1'b0;
         byte_o = ~b[i]; // The byte is not held once the strobe has gone.
         repeat (10) @(negedge link_clk_i);
      end
   endtask
endmodule // rdce_host_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the direct command engine.
`default_nettype none
module testbench import rdce_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, lclk, stb, first, op_done, rx_wait, rn_valid;
   logic [7:0] lbyte, tx_set;
   logic [15:0] rn, tx_len, handle;
   rdce_status_t st;
   rdce_pulse_t pul, pacc;
   rdce_tx_req_t tx, tx_seen;
   rdce_fifo_t ff;
   logic [7:0] fq[$];
   int gos, miscompares, total_checks;
   rdce_top rdce_top_inst (.CLOCK_I(clk), .RST_B_I(rst_n), .LINK_CLK_I(lclk), .LINK_BYTE_STB_I(stb),
      .LINK_BYTE_FIRST_I(first), .LINK_BYTE_I(lbyte), .OP_DONE_I(op_done), .RX_WAIT_DONE_I(rx_wait),
      .RN_VALID_I(rn_valid), .RN_I(rn), .STATUS_O(st), .PULSE_O(pul), .TX_REQ_O(tx), .FIFO_O(ff),
      .TX_LEN_O(tx_len), .TX_SETTINGS_O(tx_set), .HANDLE_O(handle));
   rdce_host_model rdce_host_model_inst (.link_clk_i(lclk), .stb_o(stb), .first_o(first), .byte_o(lbyte));
   // System clock at 8 ns and link clock at 6 ns with an unrelated phase.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #1.3;
      forever #3 lclk = ~lclk;
   end
   // Records pulses, transmit requests and queue pushes.
   always @(posedge clk) begin
      pacc <= pacc | pul;
      if (tx.go === 1'b1) begin
         gos <= gos + 1;
         tx_seen <= tx;
      end
      if (ff.push === 1'b1) fq.push_back(ff.data);
   end
   // Compares a value seen with the value expected.
   task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
      end
   endtask
   // Clears the records, sends a frame and lets it settle.
   task automatic frame(input logic [7:0] b[$]);
      @(negedge clk);
      pacc = '0;
      gos = 0;
      fq.delete();
      rdce_host_model_inst.send(b);
      repeat (12) @(negedge clk);
   endtask
   // One-cycle pulse on an event input.
   task automatic pulse_in(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      repeat (6) @(negedge clk);
   endtask
   // Decoder hands over a received number.
   task automatic give_rn(input logic [15:0] v);
      @(negedge clk);
      fq.delete();
      rn_valid = 1'b1;
      rn = v;
      @(negedge clk);
      rn_valid = 1'b0;
      rn = ~v;
      repeat (6) @(negedge clk);
   endtask
   task automatic t_reset();
      chk("status", st, 8'h00);
      chk("regs", {tx_len, tx_set, handle}, 40'h0);
      $display("test reset done");
   endtask
   // Code, expected status and expected pulses for immediate commands and for two unknown codes.
   task automatic t_imm();
      logic [27:0] t[$] = '{28'h8180001, 28'h85C0001, 28'h8480001, 28'h96A0001, 28'h9780021, 28'hA684001,
         28'hA780001, 28'hAA82001, 28'hAB80001, 28'hA380001, 28'hA580001, 28'h8980081, 28'h8A80041,
         28'hA880011, 28'hA980009, 28'h8080001, 28'h8280000, 28'hBF80000};
      foreach (t[i]) begin
         frame('{t[i][27:20]});
         chk("status", st, t[i][19:12]);
         chk("pulses", pacc, t[i][10:0]);
      end
      frame('{8'h96});
      pulse_in(rx_wait);
      chk("unblock", st.rx_blocked, 1'b0);
      $display("test immediate done");
   endtask
   task automatic t_lasting();
      logic [19:0] t[4] = '{20'h87200, 20'h88100, 20'hA2004, 20'hA4002};
      foreach (t[i]) begin
         frame('{t[i][19:12]});
         chk("busy", st.busy, 1'b1);
         chk("start", pacc, t[i][10:0]);
         pacc = '0;
         pulse_in(op_done);
         chk("idle", st.busy, 1'b0);
         chk("done", pacc, 11'h001);
      end
      $display("test lasting done");
   endtask
   task automatic t_tx();
      logic [7:0] c[3] = '{8'h90, 8'h91, 8'h92};
      foreach (c[i]) begin
         frame('{c[i], 8'h3D, 8'h00, 8'h30, 8'hAA, 8'hBB});
         chk("len", tx_len, 16'h0030);
         chk("gos", gos, 1);
         chk("frame", tx_seen.frame, FRM_RAW);
         chk("crc", tx_seen.crc16, c[i] != 8'h92);
         chk("hdr", tx_seen.header, c[i] == 8'h91);
         chk("fifo", {fq.size(), fq[0], fq[1]}, {32'd2, 16'hAABB});
      end
      $display("test transmit done");
   endtask
   task automatic t_query();
      frame('{8'h98, 8'h3F, 8'h12, 8'h35});
      chk("qframe", tx_seen.frame, FRM_QUERY);
      chk("qparam", tx_seen.param, 15'h091A);
      give_rn(16'hBEEF);
      chk("handle", handle, 16'hBEEF);
      chk("rnfifo", {fq.size(), fq[0], fq[1]}, {32'd2, 16'hBEEF});
      frame('{8'h9D});
      chk("ack", {tx_seen.frame, tx_seen.rn}, {FRM_ACK, 16'hBEEF});
      frame('{8'h9F});
      chk("reqrn", {tx_seen.frame, tx_seen.rn}, {FRM_REQRN, 16'hBEEF});
      give_rn(16'h5678);
      chk("newh", {handle, fq[0], fq[1]}, {16'h5678, 16'h5678});
      frame('{8'h9E});
      chk("nak", tx_seen.frame, FRM_NAK);
      $display("test query done");
   endtask
   task automatic t_qadj();
      logic [7:0] c[4] = '{8'h99, 8'h9A, 8'h9B, 8'h9C};
      frame('{8'h3C, 8'h02});
      chk("settings", tx_set, 8'h02);
      foreach (c[i]) begin
         frame('{c[i]});
         chk("sess", tx_seen.sess, 2'h2);
         chk("kind", tx_seen.frame, (i == 0) ? FRM_QREP : FRM_QADJ);
         if (i > 0) chk("adj", tx_seen.adj, i - 1);
      end
      $display("test query adjust done");
   endtask
   task automatic t_soft();
      frame('{8'h3C, 8'h01, 8'h00, 8'h40});
      frame('{8'hA6});
      frame('{8'h83});
      chk("status", st, 8'h80);
      chk("regs", {tx_len, tx_set}, 24'h0);
      chk("pulse", pacc, 11'h401);
      $display("test soft init done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run of some 9 us.
   initial begin
      #300us;
      miscompares++;
      complete_run();
   end
   // Reset, then the scenarios in turn.
   initial begin
      rst_n = 1'b0;
      op_done = 1'b0;
      rx_wait = 1'b0;
      rn_valid = 1'b0;
      rn = 16'h0000;
      pacc = '0;
      gos = 0;
      miscompares = 0;
      total_checks = 0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_imm();
      t_lasting();
      t_tx();
      t_query();
      t_qadj();
      t_soft();
      complete_run();
   end
endmodule // testbench
`default_nettype wire
